// ===== rtl/ufoe_ctrl.sv
// OUT endpoint control, interrupt flags and endpoint-0 transfer size
`timescale 1ns/10ps
`default_nettype none
`include "ufoe_defines.svh"
module ufoe_ctrl import ufoe_pkg::*; #(
	parameter int AW = `UFOE_ADDR_W
) (
	input  wire logic          clk_in,
	input  wire logic          nrst_in,
	input  wire logic [AW-1:0] addr_in,
	input  wire logic [31:0]   wdata_in,
	input  wire logic          wr_in,
	input  wire logic          rd_in,
	output var  logic [31:0]   rdata_out,
	input  wire logic [1:0]    ep_type_in,
	input  wire logic          setup_pkt_in,
	input  wire logic          out_token_in,
	input  wire logic          data_pkt_in,
	input  wire logic          xfer_last_in,
	output var  logic          accept_data_out,
	output var  logic          nak_active_status_out,
	output var  logic          pid_odd_out,
	output var  logic          endpoint_enable_out,
	output var  logic          any_out_endpoint_pending_out,
	output var  logic          irq_out
);
	// Bus-side events arrive from the link logic as level pulses on pins; only rising edges count
	logic [3:0] ev_lvl;

	ufoe_sync #(
		.W(4)
	) u_sync (
		.clk_in (clk_in),
		.nrst_in(nrst_in),
		.d_in   ({xfer_last_in, data_pkt_in, out_token_in, setup_pkt_in}),
		.q_out  (ev_lvl)
	);

	typedef struct packed {
		logic [3:0]   ev_prev;
		ufoe_state_t  state;
		logic         nak;
		logic         pid_odd;
		logic         en;
		logic         dis;
		logic         dis_flag_pend;
		logic [6:0]   flags;
		logic [6:0]   mask;
		logic [6:0]   byte_cnt;
		logic         pkt_cnt;
		logic [1:0]   setup_allow;
		logic [2:0]   setup_run;
		logic [31:0]  rdata;
		logic         accept;
		logic         pending;
		logic         irq;
	} ufoe_ctrl_st_t;

	ufoe_ctrl_st_t st_q;
	ufoe_ctrl_st_t st_d;

	ufoe_eptype_t ep_type;
	logic         ev_setup;
	logic         ev_token;
	logic         ev_data;
	logic         ev_last;
	logic         wr_ctrl;
	logic         wr_flags;
	logic         wr_size;
	logic         is_ctrl;
	logic [6:0]   set_ev;
	logic [31:0]  ctrl_view;

	assign ep_type  = ufoe_eptype_t'(ep_type_in);
	assign is_ctrl  = (ep_type == UFOE_TYPE_CTRL);
	assign ev_setup = ev_lvl[0] & ~st_q.ev_prev[0];
	assign ev_token = ev_lvl[1] & ~st_q.ev_prev[1];
	assign ev_data  = ev_lvl[2] & ~st_q.ev_prev[2];
	assign ev_last  = ev_lvl[3] & ~st_q.ev_prev[3];
	assign wr_ctrl  = wr_in && (addr_in == `UFOE_OFF_CTRL);
	assign wr_flags = wr_in && (addr_in == `UFOE_OFF_FLAGS);
	assign wr_size  = wr_in && (addr_in == `UFOE_OFF_SIZE);

	// Write-only strobes 26..29 are never stored, so they read zero
	always_comb begin
		ctrl_view = '0; // RULE18
		ctrl_view[`UFOE_CTRL_EN]     = st_q.en;
		ctrl_view[`UFOE_CTRL_DIS]    = st_q.dis;
		ctrl_view[`UFOE_CTRL_NAK_STAT] = st_q.nak;
		ctrl_view[`UFOE_CTRL_PIDODD] = st_q.pid_odd;
		ctrl_view[`UFOE_CTRL_EPTYPE_LO+1:`UFOE_CTRL_EPTYPE_LO] = ep_type_in;
	end

	always_comb begin
		st_d         = st_q;
		st_d.ev_prev = ev_lvl;
		set_ev       = '0;

		if (wr_ctrl && wdata_in[`UFOE_CTRL_NAK_CLR]) begin
			st_d.nak = 1'b0; // RULE1
		end
		if (wr_ctrl && wdata_in[`UFOE_CTRL_NAK_SET]) begin
			st_d.nak = 1'b1; // RULE2
		end
		if (wr_ctrl && wdata_in[`UFOE_CTRL_EVEN]) begin
			st_d.pid_odd = 1'b0; // RULE3
		end
		if (wr_ctrl && wdata_in[`UFOE_CTRL_ODD]) begin
			st_d.pid_odd = 1'b1; // RULE4
		end
		if (ev_data && st_q.en && !st_q.nak && ep_type != UFOE_TYPE_ISO) begin
			st_d.pid_odd = ~st_q.pid_odd;
		end

		case (st_q.state)
			UFOE_ST_IDLE: begin
				if (wr_ctrl && wdata_in[`UFOE_CTRL_EN]) begin
					st_d.en    = 1'b1; // RULE7
					st_d.state = UFOE_ST_RUN;
				end
			end
			UFOE_ST_RUN: begin
				// Disable is accepted only on a running endpoint
				if (wr_ctrl && wdata_in[`UFOE_CTRL_DIS]) begin
					st_d.dis   = 1'b1; // RULE5
					st_d.state = UFOE_ST_STOP;
				end else if (ev_setup && is_ctrl) begin
					st_d.en    = 1'b0; // RULE7
					st_d.state = UFOE_ST_IDLE;
				end else if (ev_data && ev_last && !st_q.nak) begin
					st_d.en    = 1'b0; // RULE7
					st_d.state = UFOE_ST_IDLE;
				end
			end
			UFOE_ST_STOP: begin
				// Disable bit drops one cycle ahead of its flag
				st_d.dis           = 1'b0; // RULE6
				st_d.en            = 1'b0; // RULE7
				st_d.dis_flag_pend = 1'b1;
				st_d.state         = UFOE_ST_IDLE;
			end
			default: begin
				st_d.state = UFOE_ST_IDLE;
			end
		endcase

		if (st_q.dis_flag_pend) begin
			st_d.dis_flag_pend = 1'b0;
			set_ev[`UFOE_FLG_DIS] = 1'b1; // RULE6 RULE10
		end
		if (st_q.state == UFOE_ST_RUN && ev_data && ev_last && !st_q.nak) begin
			set_ev[`UFOE_FLG_DONE] = 1'b1; // RULE10
		end
		if (is_ctrl && ev_setup) begin
			set_ev[`UFOE_FLG_SETUP] = 1'b1; // RULE11
		end
		if (is_ctrl && ev_token && !st_q.en) begin
			set_ev[`UFOE_FLG_OTOFF] = 1'b1; // RULE12
		end

		// Back-to-back SETUP counter; any other token breaks the run
		if (ev_setup) begin
			if (st_q.setup_run != 3'h7) begin
				st_d.setup_run = st_q.setup_run + 3'h1;
			end
			if (is_ctrl && st_q.setup_run >= 3'(`UFOE_SETUP_LIMIT)) begin
				set_ev[`UFOE_FLG_BURST] = 1'b1; // RULE13
			end
			if (st_q.setup_allow != 2'h0) begin
				st_d.setup_allow = st_q.setup_allow - 2'h1; // RULE16
			end
		end else if (ev_token) begin
			st_d.setup_run = '0;
		end

		if (wr_size) begin
			st_d.byte_cnt    = wdata_in[`UFOE_SIZE_CNT_MSB:0]; // RULE14
			st_d.pkt_cnt     = wdata_in[`UFOE_SIZE_PKT];
			st_d.setup_allow = wdata_in[`UFOE_SIZE_SP_HI:`UFOE_SIZE_SP_LO]; // RULE16
		end else if (ev_data && st_q.en && !st_q.nak) begin
			st_d.pkt_cnt = 1'b0; // RULE15
		end

		// Set wins over a simultaneous write-one clear
		if (wr_flags) begin
			st_d.flags = st_q.flags & ~wdata_in[6:0]; // RULE10
		end
		st_d.flags = st_d.flags | set_ev;
		if (wr_in && addr_in == `UFOE_OFF_MASK) begin
			st_d.mask = wdata_in[6:0];
		end

		st_d.accept  = st_d.en && !st_d.nak; // RULE19
		st_d.pending = |st_d.flags; // RULE9
		st_d.irq     = |(st_d.flags & st_d.mask);

		st_d.rdata = '0;
		if (rd_in) begin
			case (addr_in)
				`UFOE_OFF_CTRL:  st_d.rdata = ctrl_view;
				`UFOE_OFF_FLAGS: st_d.rdata = {25'h0, st_q.flags} | `UFOE_FLAGS_RESET;
				`UFOE_OFF_MASK:  st_d.rdata = {25'h0, st_q.mask};
				`UFOE_OFF_SIZE:  st_d.rdata = {1'b0, st_q.setup_allow, 9'h0, st_q.pkt_cnt,
					12'h0, st_q.byte_cnt};
				`UFOE_OFF_IRQ:   st_d.rdata = {30'h0, st_q.irq, st_q.pending};
				default:         st_d.rdata = '0;
			endcase
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q       <= '0;
			st_q.state <= UFOE_ST_IDLE;
		end else begin
			st_q <= st_d;
		end
	end

	assign rdata_out                    = st_q.rdata;
	assign accept_data_out              = st_q.accept;
	assign nak_active_status_out        = st_q.nak;
	assign pid_odd_out                  = st_q.pid_odd;
	assign endpoint_enable_out          = st_q.en;
	assign any_out_endpoint_pending_out = st_q.pending;
	assign irq_out                      = st_q.irq;

	AST_NAK_SET: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE2
		wr_ctrl && wdata_in[`UFOE_CTRL_NAK_SET] |=> nak_active_status_out)
		else $error("nak set write did not set status");
	AST_NAK_CLR: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE1
		wr_ctrl && wdata_in[`UFOE_CTRL_NAK_CLR] && !wdata_in[`UFOE_CTRL_NAK_SET]
		|=> !nak_active_status_out)
		else $error("nak clear write did not clear status");
	AST_PID_EVEN: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE3
		wr_ctrl && wdata_in[`UFOE_CTRL_EVEN] && !wdata_in[`UFOE_CTRL_ODD] && !ev_data
		|=> !pid_odd_out)
		else $error("even force ignored");
	AST_PID_ODD: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE4
		wr_ctrl && wdata_in[`UFOE_CTRL_ODD] && !ev_data |=> pid_odd_out)
		else $error("odd force ignored");
	AST_DIS_ONLY_EN: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE5
		$rose(st_q.dis) |-> $past(st_q.en))
		else $error("disable set while endpoint not enabled");
	AST_DIS_BEFORE_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE6
		$rose(st_q.dis) |=> !st_q.dis ##1 st_q.flags[`UFOE_FLG_DIS])
		else $error("disable flag order wrong");
	AST_EN_DROP: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE7
		st_q.state == UFOE_ST_RUN && ev_setup && is_ctrl && !wr_ctrl
		|=> !endpoint_enable_out)
		else $error("enable not cleared on setup done");
	AST_PENDING: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE9
		(|st_q.flags) |-> any_out_endpoint_pending_out)
		else $error("pending dropped with flags set");
	AST_SETUP_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE11
		ev_setup && is_ctrl |=> st_q.flags[`UFOE_FLG_SETUP])
		else $error("setup flag missing");
	AST_OTOFF_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE12
		ev_token && is_ctrl && !st_q.en |=> st_q.flags[`UFOE_FLG_OTOFF])
		else $error("out token while off flag missing");
	AST_PKT_DROP: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE15
		ev_data && st_q.en && !st_q.nak && !wr_size |=> !st_q.pkt_cnt)
		else $error("packet count did not drop");
	AST_NAK_BLOCK: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE19
		nak_active_status_out |-> !accept_data_out)
		else $error("data accepted under nak");

	// Enable life cycle, sticky flags, size fields, set/clear bits, parity hold and pending
	AST_ACCEPT: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE19
		endpoint_enable_out && !nak_active_status_out |-> accept_data_out)
		else $error("enabled endpoint refuses data without nak");
	AST_EN_SET: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE7
		st_q.state == UFOE_ST_IDLE && wr_ctrl && wdata_in[`UFOE_CTRL_EN]
		|=> endpoint_enable_out)
		else $error("enable write ignored");
	AST_DONE_EN: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE7
		st_q.state == UFOE_ST_RUN && ev_data && ev_last && !st_q.nak && !wr_ctrl
		|=> !endpoint_enable_out)
		else $error("enable not cleared on transfer done");
	AST_DIS_EN_DROP: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE7
		$rose(st_q.dis) |=> !endpoint_enable_out)
		else $error("enable not cleared on disable");
	AST_DIS_REFUSED: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE5
		st_q.state != UFOE_ST_RUN |=> !st_q.dis)
		else $error("disable taken on idle endpoint");
	AST_DIS_FLAG_LOW: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE6
		$rose(st_q.flags[`UFOE_FLG_DIS]) |-> !st_q.dis)
		else $error("disabled flag raised while disable bit set");
	AST_DONE_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE10
		st_q.state == UFOE_ST_RUN && ev_data && ev_last && !st_q.nak
		|=> st_q.flags[`UFOE_FLG_DONE])
		else $error("transfer done flag missing");
	AST_FLAG_STICKY: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE10
		st_q.flags[`UFOE_FLG_DONE] && !(wr_flags && wdata_in[`UFOE_FLG_DONE])
		|=> st_q.flags[`UFOE_FLG_DONE])
		else $error("done flag lost without a clear");
	AST_FLAG_CLEAR: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE10
		wr_flags && wdata_in[`UFOE_FLG_DONE] && !set_ev[`UFOE_FLG_DONE]
		|=> !st_q.flags[`UFOE_FLG_DONE])
		else $error("done flag survived a write of one");
	AST_SETUP_OFF: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE11
		ev_setup && !is_ctrl && !st_q.flags[`UFOE_FLG_SETUP]
		|=> !st_q.flags[`UFOE_FLG_SETUP])
		else $error("setup flag set on non-control endpoint");
	AST_OTOFF_QUIET: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE12
		ev_token && st_q.en && !st_q.flags[`UFOE_FLG_OTOFF]
		|=> !st_q.flags[`UFOE_FLG_OTOFF])
		else $error("out token flag set on enabled endpoint");
	AST_BURST_FLAG: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE13
		ev_setup && is_ctrl && st_q.setup_run >= 3'(`UFOE_SETUP_LIMIT)
		|=> st_q.flags[`UFOE_FLG_BURST])
		else $error("back to back setup flag missing");
	AST_BURST_EARLY: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE13
		ev_setup && st_q.setup_run < 3'(`UFOE_SETUP_LIMIT) && !st_q.flags[`UFOE_FLG_BURST]
		|=> !st_q.flags[`UFOE_FLG_BURST])
		else $error("back to back setup flag set too early");
	AST_SIZE_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE14
		wr_size |=> st_q.byte_cnt == $past(wdata_in[`UFOE_SIZE_CNT_MSB:0]))
		else $error("byte count write lost");
	AST_PKT_KEEP: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE15
		!wr_size && !(ev_data && st_q.en && !st_q.nak) |=> $stable(st_q.pkt_cnt))
		else $error("packet count moved without a packet");
	AST_ALLOW_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE16
		wr_size |=> st_q.setup_allow == $past(wdata_in[`UFOE_SIZE_SP_HI:`UFOE_SIZE_SP_LO]))
		else $error("setup allowance write lost");
	AST_ALLOW_DEC: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE16
		ev_setup && !wr_size && st_q.setup_allow != 2'h0
		|=> st_q.setup_allow == $past(st_q.setup_allow) - 2'h1)
		else $error("setup allowance not decremented");
	AST_WO_READ_ZERO: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE18
		rd_in && addr_in == `UFOE_OFF_CTRL
		|=> rdata_out[`UFOE_CTRL_ODD:`UFOE_CTRL_NAK_CLR] == 4'h0)
		else $error("write-only control bits read back");
	AST_ZERO_WRITE: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE18
		wr_ctrl && wdata_in[`UFOE_CTRL_ODD:`UFOE_CTRL_NAK_CLR] == 4'h0 && !ev_data
		|=> $stable(nak_active_status_out) && $stable(pid_odd_out))
		else $error("zero write to set or clear bits had an effect");
	AST_PID_HOLD_ISO: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE4
		ep_type == UFOE_TYPE_ISO && !wr_ctrl |=> $stable(pid_odd_out))
		else $error("frame parity moved without a force");
	AST_PEND_CLEAR: assert property (@(posedge clk_in) disable iff (!nrst_in) // RULE9
		!(|st_q.flags) |-> !any_out_endpoint_pending_out)
		else $error("pending left set with no flag");
endmodule // ufoe_ctrl
`default_nettype wire

// ===== rtl/ufoe_defines.svh
// Register offsets, field positions, reset values and the rule summary
// Function
// (RULE1) Writing one to control bit 26 clears the endpoint NAK status.
// (RULE2) Writing one to control bit 27 sets NAK status; endpoint answers NAK.
// (RULE3) Bit 28 forces DATA0 for bulk/interrupt, even frame for isochronous.
// (RULE4) Bit 29 forces odd frame for isochronous, DATA1 for bulk/interrupt.
// (RULE5) Disable bit 30 stops transfers; settable only while enable is set.
// (RULE6) Disable bit clears before the endpoint-disabled flag is raised.
// (RULE7) Enable bit 31 starts transfers; cleared on setup done, disable, completion.
// (RULE8) Software reads endpoint flags only after global and all-endpoint flags.
// (RULE9) Endpoint and global pending bits stay set until all endpoint flags clear.
// (RULE10) Flag 0 on transfer done, flag 1 on disabled; write one clears.
// (RULE11) Control endpoint: flag 3 when SETUP stage finishes.
// (RULE12) Control endpoint: flag 4 on OUT token while not enabled.
// (RULE13) Control endpoint: flag 6 after more than three back-to-back SETUPs.
// (RULE14) Endpoint 0 transfer size is a byte count in field 6:0.
// (RULE15) Endpoint 0 packet count bit 19 drops to zero after packet stored.
// (RULE16) Field 30:29 holds back-to-back SETUP allowance: 01, 10, 11.
// (RULE17) Software writes size register only while enabled, reads when disabled.
// (RULE18) Set/clear bits 26 to 29 ignore zero writes and read as zero.
// (RULE19) NAK status stops data acceptance but SETUP packets still acknowledged.
`ifndef UFOE_DEFINES_SVH
`define UFOE_DEFINES_SVH

`define UFOE_ADDR_W        12
`define UFOE_OFF_CTRL      12'hb00
`define UFOE_OFF_FLAGS     12'hb08
`define UFOE_OFF_SIZE      12'hb10
`define UFOE_OFF_MASK      12'hb0c
`define UFOE_OFF_IRQ       12'hb14
`define UFOE_FLAGS_RESET   32'h0000_0080
`define UFOE_SIZE_RESET    32'h0000_0000
`define UFOE_CTRL_EPTYPE_LO 18
`define UFOE_CTRL_NAK_STAT 17
`define UFOE_CTRL_PIDODD   16
`define UFOE_CTRL_NAK_CLR  26
`define UFOE_CTRL_NAK_SET  27
`define UFOE_CTRL_EVEN     28
`define UFOE_CTRL_ODD      29
`define UFOE_CTRL_DIS      30
`define UFOE_CTRL_EN       31
`define UFOE_FLG_DONE      0
`define UFOE_FLG_DIS       1
`define UFOE_FLG_SETUP     3
`define UFOE_FLG_OTOFF     4
`define UFOE_FLG_BURST     6
`define UFOE_FLG_MASK      32'h0000_005b
`define UFOE_SIZE_CNT_MSB  6
`define UFOE_SIZE_PKT      19
`define UFOE_SIZE_SP_LO    29
`define UFOE_SIZE_SP_HI    30
`define UFOE_SETUP_LIMIT   3

`endif

// ===== rtl/ufoe_pkg.sv
// Types shared by the OUT endpoint control block
package ufoe_pkg;
	typedef enum logic [1:0] {
		UFOE_TYPE_CTRL = 2'h0,
		UFOE_TYPE_ISO  = 2'h1,
		UFOE_TYPE_BULK = 2'h2,
		UFOE_TYPE_INTR = 2'h3
	} ufoe_eptype_t;

	typedef enum logic [2:0] {
		UFOE_ST_IDLE = 3'h1,
		UFOE_ST_RUN  = 3'h2,
		UFOE_ST_STOP = 3'h4
	} ufoe_state_t;
endpackage

// ===== rtl/ufoe_sync.sv
// Three-stage input synchroniser with agreement on the last two stages
`timescale 1ns/10ps
`default_nettype none
module ufoe_sync #(
	parameter int W = 1
) (
	input  wire logic         clk_in,
	input  wire logic         nrst_in,
	input  wire logic [W-1:0] d_in,
	output var  logic [W-1:0] q_out
);
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
		logic [W-1:0] s3;
		logic [W-1:0] q;
	} ufoe_sync_st_t;

	ufoe_sync_st_t st_q;
	ufoe_sync_st_t st_d;

	always_comb begin
		st_d    = st_q;
		st_d.s1 = d_in;
		st_d.s2 = st_q.s1;
		st_d.s3 = st_q.s2;
		for (int i = 0; i < W; i++) begin
			if (st_q.s2[i] == st_q.s3[i]) begin
				st_d.q[i] = st_q.s3[i];
			end
		end
	end

	always_ff @(posedge clk_in or negedge nrst_in) begin
		if (!nrst_in) begin
			st_q <= '0;
		end else begin
			st_q <= st_d;
		end
	end

	assign q_out = st_q.q;
endmodule // ufoe_sync
`default_nettype wire

// ===== verification/tb_ufoe_ctrl.sv
// Self-checking bench for the OUT endpoint control block
`timescale 1ns/10ps
`default_nettype none
`include "ufoe_defines.svh"
module tb_ufoe_ctrl import ufoe_pkg::*;;
	logic        clk_in = 1'b0, nrst_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
	logic [11:0] addr_in = 12'h000;
	logic [31:0] wdata_in = 32'h0, rdata_out, m_flags, m_mask, m_size, rnd;
	logic [1:0]  ep_type_in = 2'h0;
	logic        stp, tok, dat, lst, acc, nak, pid, en, pend, irq;
	logic        m_en = 1'b0, m_nak = 1'b0, m_pid = 1'b0;
	int          errors = 0, cmp_count = 0, cycles = 0, cons = 0;

	ufoe_ctrl u_dut (.clk_in(clk_in), .nrst_in(nrst_in), .addr_in(addr_in),
		.wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out),
		.ep_type_in(ep_type_in), .setup_pkt_in(stp), .out_token_in(tok),
		.data_pkt_in(dat), .xfer_last_in(lst), .accept_data_out(acc),
		.nak_active_status_out(nak), .pid_odd_out(pid), .endpoint_enable_out(en),
		.any_out_endpoint_pending_out(pend), .irq_out(irq));
	ufoe_host_model u_host (.clk_in(clk_in), .setup_out(stp), .token_out(tok),
		.data_out(dat), .last_out(lst));

	initial begin
		forever #5 clk_in = ~clk_in;
	end
	always @(posedge clk_in) begin
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			errors = errors + 1;
			wrap_up();
		end
	end

	function automatic logic [31:0] lfsr(input logic [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	task automatic wrap_up();
		$display("errors %0d compares %0d", errors, cmp_count);
		if (errors == 0 && cmp_count > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			$display("ERROR %s expected %h seen %h", nm, e, g);
			errors++;
		end
	endtask
	task automatic settle();
		repeat (4) @(posedge clk_in);
		#1;
	endtask
	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk_in);
		addr_in  <= a;
		wdata_in <= d;
		wr_in    <= 1'b1;
		@(posedge clk_in);
		wr_in <= 1'b0;
	endtask
	task automatic rd(input logic [11:0] a, input logic [31:0] e, input string nm);
		@(posedge clk_in);
		addr_in <= a;
		rd_in   <= 1'b1;
		@(posedge clk_in);
		rd_in <= 1'b0;
		#1;
		chk(nm, e, rdata_out);
	endtask
	task automatic rdc();
		rd(`UFOE_OFF_CTRL, {m_en, 11'h0, ep_type_in, m_nak, m_pid, 16'h0}, "ctrl");
	endtask
	task automatic rdf();
		rd(`UFOE_OFF_FLAGS, m_flags | `UFOE_FLAGS_RESET, "flags");
	endtask
	task automatic chkp();
		chk("ports", 32'({m_en & ~m_nak, m_nak, m_pid, m_en, |m_flags, |(m_flags & m_mask)}),
			32'({acc, nak, pid, en, pend, irq}));
	endtask
	task automatic ctl(input logic [31:0] d);
		wr(`UFOE_OFF_CTRL, d);
		// Disable is honoured only on a running endpoint
		if (d[30] && m_en) begin
			m_en = 1'b0;
			m_flags[1] = 1'b1;
		end
		if (d[31]) m_en = 1'b1;
		if (d[26]) m_nak = 1'b0;
		if (d[27]) m_nak = 1'b1;
		if (d[28]) m_pid = 1'b0;
		if (d[29]) m_pid = 1'b1;
		settle();
	endtask
	task automatic ev(input int k, input logic last);
		u_host.send(k, last);
		if (k == 0) begin
			cons++;
			// Setup flag, enable drop and burst flag belong to control endpoints only
			if (ep_type_in == UFOE_TYPE_CTRL) begin
				m_flags[3] = 1'b1;
				m_en = 1'b0;
				if (cons > `UFOE_SETUP_LIMIT) m_flags[6] = 1'b1;
			end
			if (m_size[30:29] != 2'h0) m_size[30:29] = m_size[30:29] - 2'h1;
		end else if (k == 1) begin
			cons = 0;
			if (!m_en && ep_type_in == UFOE_TYPE_CTRL) m_flags[4] = 1'b1;
		end else if (m_en && !m_nak) begin
			m_size[19] = 1'b0;
			if (ep_type_in != UFOE_TYPE_ISO) m_pid = ~m_pid;
			if (last) begin
				m_flags[0] = 1'b1;
				m_en = 1'b0;
			end
		end
		settle();
	endtask

	initial begin
		rnd = 32'h0001_27b0;
		m_flags = 32'h0;
		m_size = 32'h0;
		repeat (8) @(posedge clk_in);
		nrst_in <= 1'b1;
		rd(`UFOE_OFF_FLAGS, `UFOE_FLAGS_RESET, "flags");
		rd(`UFOE_OFF_SIZE, `UFOE_SIZE_RESET, "size");
		rd(12'hb04, 32'h0, "unmapped");
		rnd = lfsr(rnd);
		m_mask = rnd & `UFOE_FLG_MASK;
		wr(`UFOE_OFF_MASK, m_mask);
		ctl(32'h0800_0000);
		chkp();
		ctl(32'h0);
		rdc();
		ctl(32'h0400_0000);
		chkp();
		for (int t = 0; t < 4; t++) begin
			@(posedge clk_in) ep_type_in <= t[1:0];
			ctl(32'h2000_0000);
			chkp();
			ctl(32'h1000_0000);
			chkp();
		end
		@(posedge clk_in) ep_type_in <= UFOE_TYPE_BULK;
		ctl(32'h4000_0000);
		rdc();
		ctl(32'h8000_0000);
		chkp();
		ctl(32'h4000_0000);
		rdc();
		rdf();
		ctl(32'h8000_0000);
		rnd = lfsr(rnd);
		m_size = (rnd & 32'h7f) | 32'h6008_0000;
		wr(`UFOE_OFF_SIZE, m_size);
		ev(2, 1'b0);
		chkp();
		ev(2, 1'b1);
		chkp();
		rd(`UFOE_OFF_SIZE, m_size, "size");
		rdf();
		@(posedge clk_in) ep_type_in <= UFOE_TYPE_CTRL;
		ctl(32'h8800_0000);
		ev(2, 1'b1);
		chkp();
		ev(0, 1'b0);
		rdf();
		ev(1, 1'b0);
		rdf();
		ctl(32'h8400_0000);
		m_size = 32'h6000_0000;
		wr(`UFOE_OFF_SIZE, m_size);
		repeat (3) ev(0, 1'b0);
		rd(`UFOE_OFF_SIZE, m_size, "size");
		rdf();
		ev(0, 1'b0);
		rd(`UFOE_OFF_IRQ, {30'h0, |(m_flags & m_mask), |m_flags}, "status");
		rdf();
		@(posedge clk_in) ep_type_in <= UFOE_TYPE_ISO;
		ctl(32'h8000_0000);
		ev(2, 1'b1);
		chkp();
		m_mask = `UFOE_FLG_MASK;
		wr(`UFOE_OFF_MASK, m_mask);
		wr(`UFOE_OFF_FLAGS, 32'h1);
		m_flags[0] = 1'b0;
		settle();
		chkp();
		wr(`UFOE_OFF_FLAGS, 32'hff);
		m_flags = 32'h0;
		settle();
		chkp();
		rdf();
		wrap_up();
	end
endmodule // tb_ufoe_ctrl
`default_nettype wire

// ===== verification/ufoe_host_model.sv
// Host-side model driving token and packet event pins
`timescale 1ns/10ps
`default_nettype none
module ufoe_host_model (
	input  wire logic clk_in,
	output var  logic setup_out,
	output var  logic token_out,
	output var  logic data_out,
	output var  logic last_out
);
	initial {setup_out, token_out, data_out, last_out} = 4'h0;
	// Three cycles high and low clears the input synchroniser
	task automatic send(input int k, input logic last);
		@(posedge clk_in);
		setup_out <= (k == 0);
		token_out <= (k == 1);
		data_out  <= (k == 2);
		last_out  <= last;
		repeat (3) @(posedge clk_in);
		{setup_out, token_out, data_out, last_out} <= 4'h0;
		repeat (3) @(posedge clk_in);
	endtask
endmodule // ufoe_host_model
`default_nettype wire
